// [hdl/fbm_host.sv]
/*
 * Host-side controller that runs read, command-write and identification cycles on a byte-wide flash.
 * Assumes the flash pins are driven straight from this block and the data lines are resolved outside.
 */
// Behaviour
// - Read: chip-select and output-enable low, write-enable high; flash returns data.
// - Write: write-enable and chip-select low, output-enable high; only this is a write.
// - Chip-select high is standby; allow full chip-select access time before read data.
// - In-system hosts use the command route, never the elevated level on the select pin.
// - Autoselect persists until the host writes the reset command.
`timescale 1ns/1ns
module fbm_host (
	input  wire logic            clock,
	input  wire logic            rstn,
	input  wire logic            reqValid,
	output logic                 reqReady,
	input  wire fbm_pkg::fbm_req_t req,
	output logic                 rspValid,
	output logic [7:0]           rspData,
	output logic                 rspProtected,
	output logic [2:0]           curSector,
	output fbm_pkg::fbm_pins_t   pins,
	input  wire logic [7:0]      dqIn,
	output logic                 elevatedSelectEn
);
	import fbm_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_READ, ST_WPULSE, ST_WHOLD, ST_DESEL} fbm_state_t;

	fbm_state_t             state_q, state_d;
	fbm_pins_t              pins_q, pins_d;
	fbm_kind_t              kind_q, kind_d;
	logic [CNT_W-1:0]       cnt_q, cnt_d;
	logic                   rspValid_q, rspValid_d;
	logic [DATA_W-1:0]      rspData_q, rspData_d;
	logic [ADDR_W-1:0]      pinAddr;

	// ************************************************************
	// Address shaping for identification cycles
	// ************************************************************

	// Identification reads force A6/A1/A0; the protection check keeps only the sector bits.
	always_comb begin
		case (req.kind)
			KIND_MFR_ID:     pinAddr = req.addr & ID_CLEAR_MASK;
			KIND_DEV_ID:     pinAddr = (req.addr & ID_CLEAR_MASK) | ID_A0_MASK;
			KIND_PROT_CHECK: pinAddr = (req.addr & SECTOR_MASK) | ID_A1_MASK;
			default:         pinAddr = req.addr;
		endcase
	end

	// ************************************************************
	// Bus cycle sequencer
	// ************************************************************

	// Every cycle starts and ends in standby, so each read pays the full chip-select access time.
	always_comb begin
		state_d = state_q;
		pins_d = pins_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		rspValid_d = 1'b0;
		rspData_d = rspData_q;
		case (state_q)
			ST_IDLE: begin
				if (reqValid) begin
					pins_d.ceN = 1'b0;
					pins_d.addr = pinAddr;
					pins_d.dqOut = req.data;
					pins_d.dqOe = (req.kind == KIND_WRITE);
					kind_d = req.kind;
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address settles under chip-select before either strobe falls.
				if (kind_q == KIND_WRITE) begin
					pins_d.weN = 1'b0;
					cnt_d = WP_CYC - 4'h1;
					state_d = ST_WPULSE;
				end else begin
					pins_d.oeN = 1'b0;
					cnt_d = ACC_CYC - 4'h1;
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				if (cnt_q == '0) begin
					rspData_d = dqIn;
					rspValid_d = 1'b1;
					pins_d.oeN = 1'b1;
					pins_d.ceN = 1'b1;
					state_d = ST_DESEL;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			ST_WPULSE: begin
				if (cnt_q == '0) begin
					pins_d.weN = 1'b1;
					cnt_d = WH_CYC - 4'h1;
					state_d = ST_WHOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			ST_WHOLD: begin
				// Data is kept driven past the rising write edge before the bus is released.
				if (cnt_q == '0) begin
					pins_d.dqOe = 1'b0;
					pins_d.ceN = 1'b1;
					rspValid_d = 1'b1;
					state_d = ST_DESEL;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			ST_DESEL: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Registers only; reset parks the pins in standby with the data lines released.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			pins_q <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};
			kind_q <= KIND_READ;
			cnt_q <= '0;
			rspValid_q <= 1'b0;
			rspData_q <= '0;
		end else begin
			state_q <= state_d;
			pins_q <= pins_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			rspValid_q <= rspValid_d;
			rspData_q <= rspData_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************

	// The elevated select level is never used in-system.
	assign elevatedSelectEn = 1'b0;
	assign reqReady = (state_q == ST_IDLE);
	assign pins = pins_q;
	assign rspValid = rspValid_q;
	assign rspData = rspData_q;
	assign rspProtected = (rspData_q == PROT_YES_CODE);
	assign curSector = pins_q.addr[SECTOR_MSB:SECTOR_LSB];

	// ************************************************************
	// Checks
	// ************************************************************

	// Helper counts cycles that chip-select has been low, for the access-time check.
	logic [CNT_W-1:0] selCnt_q;
	always_ff @(posedge clock) begin
		if (!rstn || pins_q.ceN)
			selCnt_q <= '0;
		else if (selCnt_q != 4'hf)
			selCnt_q <= selCnt_q + 4'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_READ_COMBO: assert property (!pins_q.oeN |-> !pins_q.ceN && pins_q.weN && !pins_q.dqOe)
		else $error("Output enable low without a clean read combination.");
	AST_WRITE_COMBO: assert property (!pins_q.weN |-> !pins_q.ceN && pins_q.oeN && pins_q.dqOe)
		else $error("Write enable low without a clean write combination.");
	AST_ACCESS_TIME: assert property (rspValid_d && kind_q != KIND_WRITE |-> selCnt_q >= ACC_CYC)
		else $error("Read data taken before the access time elapsed.");
	AST_STANDBY: assert property (state_q == ST_IDLE |-> pins_q.ceN && pins_q.oeN && pins_q.weN && !pins_q.dqOe)
		else $error("Idle bus not in standby.");
	AST_ADDR_HOLD: assert property (!pins_q.ceN && !$past(pins_q.ceN) |-> $stable(pins_q.addr))
		else $error("Address moved during a selected cycle.");
	AST_DATA_RISE: assert property ($rose(pins_q.weN) |-> pins_q.dqOe && $stable(pins_q.dqOut))
		else $error("Write data not held across the rising write edge.");
	AST_WP_WIDTH: assert property ($fell(pins_q.weN) |-> !pins_q.weN [*2] ##1 pins_q.weN)
		else $error("Write pulse width wrong.");
	AST_ID_ADDR: assert property (!pins_q.oeN && kind_q == KIND_MFR_ID |-> pins_q.addr[6:0] ==? 7'b0xxxx00)
		else $error("Maker code read with A6/A1/A0 not low.");
	AST_PROT_ADDR: assert property (!pins_q.oeN && kind_q == KIND_PROT_CHECK |-> pins_q.addr[15:0] == 16'h0002)
		else $error("Protection check address malformed.");
	AST_NO_HV: assert property (!elevatedSelectEn)
		else $error("Elevated select level requested.");
	AST_RSP_PULSE: assert property (rspValid |=> !rspValid && reqReady)
		else $error("Answer not a single pulse before standby.");
	// A read strobe held too short would capture before the output access time has run.
	AST_READ_LEN: assert property ($fell(pins_q.oeN) |-> !pins_q.oeN [*4] ##1 pins_q.oeN)
		else $error("Read strobe width wrong.");
	// At least two standby cycles between accesses, so every read pays the full chip-select access time.
	AST_DESEL_GAP: assert property ($rose(pins_q.ceN) |=> pins_q.ceN)
		else $error("Chip-select reasserted without a standby cycle.");
	// Deselected means released: no strobe and no data drive while chip-select is high.
	AST_DQ_RELEASE: assert property (pins_q.ceN |-> !pins_q.dqOe && pins_q.oeN && pins_q.weN)
		else $error("Strobe or data drive active while deselected.");
	AST_DEV_ADDR: assert property (!pins_q.oeN && kind_q == KIND_DEV_ID |-> pins_q.addr[6:0] ==? 7'b0xxxx01)
		else $error("Device code read with A6/A1 not low or A0 not high.");
	// A write is answered only once the pulse has ended and the data lines are let go.
	AST_WRITE_DONE: assert property (rspValid && kind_q == KIND_WRITE |-> pins_q.weN && !pins_q.dqOe)
		else $error("Write answered while the pulse or data drive is still active.");

	COV_READ: cover property (state_q == ST_READ ##[1:8] rspValid && kind_q == KIND_READ);
	COV_WRITE: cover property ($rose(pins_q.weN) ##[1:4] rspValid);
	COV_PROT: cover property (rspValid && kind_q == KIND_PROT_CHECK && rspProtected);
	// The device-code read of the identification set.
	COV_DEV_ID: cover property (rspValid && kind_q == KIND_DEV_ID);

endmodule : fbm_host

// [hdl/fbm_pkg.sv]
/*
 * Package for the flash bus host controller: request and pin bundles, request kinds and strobe timing.
 * Assumes a 50 MHz system clock and an asynchronous byte-wide flash device on the far side of the pins.
 */
package fbm_pkg;

	// ************************************************************
	// Widths and address fields
	// ************************************************************
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int SECTOR_MSB = 18;
	localparam int SECTOR_LSB = 16;
	localparam logic [ADDR_W-1:0] SECTOR_MASK = 19'h70000;
	localparam logic [ADDR_W-1:0] ID_CLEAR_MASK = 19'h7ffbc;
	localparam logic [ADDR_W-1:0] ID_A0_MASK = 19'h00001;
	localparam logic [ADDR_W-1:0] ID_A1_MASK = 19'h00002;
	localparam logic [DATA_W-1:0] PROT_YES_CODE = 8'h01;

	// ************************************************************
	// Strobe timing
	// ************************************************************
	localparam int CLK_NS = 20;
	localparam int T_ACC_NS = 70;
	localparam int T_WP_NS = 35;
	localparam int T_WH_NS = 20;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] WH_CYC = CNT_W'((T_WH_NS + CLK_NS - 1) / CLK_NS);

	// ************************************************************
	// Request kinds and bundles
	// ************************************************************
	typedef enum logic [2:0] {
		KIND_READ,
		KIND_WRITE,
		KIND_MFR_ID,
		KIND_DEV_ID,
		KIND_PROT_CHECK
	} fbm_kind_t;

	typedef struct packed {
		fbm_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbm_req_t;

	typedef struct packed {
		logic ceN;
		logic oeN;
		logic weN;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dqOut;
		logic dqOe;
	} fbm_pins_t;

endpackage : fbm_pkg

// [test/fbm_flash_model.sv]
/*
 * Behavioural byte-wide flash seen from its pins: read array, command writes, autoselect and busy status.
 * Assumes the host drives the strobes, address and write data; the data lines are resolved here from both sides.
 */
`timescale 1ns/1ns
module fbm_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
	parameter logic [7:0] PART_CODE  = 8'h5e, // Arbitrary value.
	parameter logic [7:0] PROT_SET   = 8'h08
) (
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  hostDq,
	input  wire logic        hostOe,
	output logic [7:0]       dqLine
);
	logic [1:0]  mode = 2'd0;
	logic [7:0]  floatPat = 8'ha5;
	logic [7:0]  rdData;
	logic [18:0] wrAddr;

	// A floating line must not look like the last byte, so it keeps changing.
	always #10 floatPat = ~floatPat;

	// Address on the later falling strobe, data and command on the earlier rising one.
	always @(negedge weN or negedge ceN) if (!weN && !ceN) wrAddr = addr;
	always @(posedge weN or posedge ceN) begin
		if (!oeN) begin
		end else if (!(ceN && weN) && mode != 2'd2) begin
			case (hostDq)
				8'h90: mode <= 2'd1;
				8'hf0: mode <= 2'd0;
				8'h10: begin
					mode <= 2'd2;
					mode <= #400 2'd0;
				end
				default: mode <= mode;
			endcase
		end
	end

	// Read source by mode; only the sector index in the top three address bits picks the protection bit.
	always_comb begin
		case (mode)
			2'd2: rdData = 8'h80;
			2'd1: rdData = addr[1] ? {7'h0, PROT_SET[addr[18:16]]} : (addr[0] ? PART_CODE : MAKER_CODE);
			default: rdData = addr[7:0] ^ {5'h0, addr[18:16]};
		endcase
	end

	assign dqLine = hostOe ? hostDq : ((!ceN && !oeN && weN) ? rdData : floatPat);
endmodule : fbm_flash_model

// [test/flash_bus_mode_decode_tb.sv]
/*
 * Self-checking bench for the flash host controller against the flash model.
 * Assumes a 50 MHz clock and the request timing described for the controller.
 */
`timescale 1ns/1ns
module flash_bus_mode_decode_tb;
	import fbm_pkg::*;
	localparam logic [7:0] MK = 8'h3c; // Arbitrary value.
	localparam logic [7:0] PT = 8'h5e; // Arbitrary value.
	typedef struct {fbm_kind_t k; logic [18:0] a; logic [7:0] d; logic [7:0] e; bit c;} fbm_row_t;
	logic clock = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqReady, rspValid, rspProtected, elevatedSelectEn;
	logic [7:0] rspData, dqIn, got;
	logic [2:0] curSector;
	fbm_req_t req = '0;
	fbm_pins_t pins;
	int miscompares = 0, total_checks = 0;
	fbm_row_t rows[13] = '{
		'{KIND_READ, 19'h00012, 8'h00, 8'h12, 1}, '{KIND_READ, 19'h7ff34, 8'h00, 8'h33, 1},
		'{KIND_WRITE, 19'h00555, 8'h90, 8'h00, 0}, '{KIND_MFR_ID, 19'h7ffff, 8'h00, MK, 1},
		'{KIND_DEV_ID, 19'h2ffc7, 8'h00, PT, 1}, '{KIND_PROT_CHECK, 19'h3abcd, 8'h00, 8'h01, 1},
		'{KIND_PROT_CHECK, 19'h50000, 8'h00, 8'h00, 1}, '{KIND_READ, 19'h00041, 8'h00, PT, 1},
		'{KIND_WRITE, 19'h00000, 8'hf0, 8'h00, 0}, '{KIND_READ, 19'h60041, 8'h00, 8'h47, 1},
		'{KIND_WRITE, 19'h10000, 8'h10, 8'h00, 0}, '{KIND_READ, 19'h00041, 8'h00, 8'h80, 1},
		'{KIND_READ, 19'h00041, 8'h00, 8'h80, 1}};

	initial forever #10 clock = ~clock;

	fbm_host u_dut (.clock(clock), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady), .req(req),
		.rspValid(rspValid), .rspData(rspData), .rspProtected(rspProtected), .curSector(curSector),
		.pins(pins), .dqIn(dqIn), .elevatedSelectEn(elevatedSelectEn));
	fbm_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT), .PROT_SET(8'h08)) u_flash (.ceN(pins.ceN),
		.oeN(pins.oeN), .weN(pins.weN), .addr(pins.addr), .hostDq(pins.dqOut), .hostOe(pins.dqOe), .dqLine(dqIn));

	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One request end to end; the strobe pair must never read and write at once.
	task automatic doReq(input fbm_kind_t k, input logic [18:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		#2;
		req = '{k, a, d};
		reqValid = 1'b1;
		@(posedge clock);
		#2;
		reqValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 12) begin
			check(19'(pins.oeN | pins.weN), 19'h1);
			@(posedge clock);
			#1;
			n++;
		end
		got = rspData;
		check(19'(n), 19'(k == KIND_WRITE ? 4 : 5));
	endtask : doReq

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report

	// Watchdog: the whole run needs a few microseconds, so this span only trips on a hang.
	initial begin
		#20000;
		miscompares++;
		final_report();
	end

	initial begin
		repeat (20) @(posedge clock);
		#2;
		check({pins.ceN, pins.oeN, pins.weN, pins.dqOe}, 4'he);
		rstn = 1'b1;
		foreach (rows[i]) begin
			doReq(rows[i].k, rows[i].a, rows[i].d);
			if (rows[i].c) check(got, rows[i].e);
			check(curSector, rows[i].a[18:16]);
			if (rows[i].k == KIND_PROT_CHECK) check(rspProtected, rows[i].e == 8'h01);
			$display("row %0d done", i);
		end
		// Busy ends on its own; array data returns with no command.
		#400;
		doReq(KIND_READ, 19'h70005, 8'h00);
		check(got, 8'h02);
		check(elevatedSelectEn, 1'b0);
		$display("idle read test done");
		// Reset in mid-read drops every strobe and the data drive.
		@(posedge clock);
		#2;
		req = '{KIND_READ, 19'h00001, 8'h00};
		reqValid = 1'b1;
		repeat (3) @(posedge clock);
		#2;
		rstn = 1'b0;
		reqValid = 1'b0;
		@(posedge clock);
		#2;
		check({pins.ceN, pins.oeN, pins.weN, pins.dqOe, rspValid}, 5'h1c);
		rstn = 1'b1;
		check(reqReady, 1'b1);
		// Array data must come straight back after the mid-run reset, with no command first.
		doReq(KIND_READ, 19'h00001, 8'h00);
		check(got, 8'h01);
		$display("reset test done");
		final_report();
	end
endmodule : flash_bus_mode_decode_tb
